// >>> sim/clock_synth_irq_flags_tb.sv
// self-checking bench of the interrupt flag block
`timescale 1ns/10ps
module clock_synth_irq_flags_tb;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] s = 8'h00;
    reg preload_valid = 1'b0;
    reg [7:0] preload_mask = 8'h00, preload_pol = 8'h00, preload_ctl = 8'h00;
    wire reg_wr, reg_rd, irq_status;
    wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
    integer n_mismatch = 0, n_checks = 0, i;
    reg [31:0] r = 32'h0001_29a8;
    reg [7:0] m, p, c, f, e;
    csif_top dut (.*, .lock_lost_a(s[7]), .signal_lost_a(s[6]), .calibrating_a(s[5]),
        .lock_lost_b(s[4]), .signal_lost_b(s[3]), .calibrating_b(s[2]),
        .ref_switch_back_a(s[1]), .ref_switch_back_b(s[0]));
    csif_host host (.*);
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input [23:0] n, input [7:0] x, input [7:0] g);
        n_checks = n_checks + 1;
        if (x !== g) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task rdc(input [7:0] a, input [7:0] x);
        host.op(1'b0, 1'b1, a, 8'h00);
        host.op(1'b0, 1'b0, a, 8'h00);
        chk("reg", x, host.q);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #20 core_clk = ~core_clk;
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 12; i < 18; i = i + 1) rdc(i[7:0], 8'h00);
        f = 8'h00;
        for (i = 0; i < 40; i = i + 1) begin
            r = nx(nx(r));
            m = (i == 3) ? 8'hff : r[7:0];
            p = r[15:8];
            c = {6'h00, r[17:16]};
            host.op(1'b1, 1'b0, 8'h11, c);
            rdc(8'h11, c);
            // clears only while enabled, so a held-off clear is never in question
            e = c[0] ? r[31:24] : 8'hff;
            host.op(1'b1, 1'b0, 8'h10, e);
            f = f & e;
            host.op(1'b1, 1'b0, 8'h0f, p);
            rdc(8'h0f, p);
            host.op(1'b1, 1'b0, 8'h0e, m);
            rdc(8'h0e, m);
            e = (p & r[25:18] & ~s) | (~p & ~r[25:18] & s);
            @(posedge core_clk);
            s <= r[25:18];
            if (c[0]) f = f | e;
            host.op(1'b0, 1'b0, 8'h00, 8'h00);
            rdc(8'h0d, s);
            rdc(8'h10, f);
            chk("irq", c[0] && (c[1] ? m != 8'hff && (f | m) == 8'hff : |(f & ~m)), irq_status);
        end
        // mid-run reset: flags and setup back to zero, live follows the sources again after release
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 12; i < 18; i = i + 1) rdc(i[7:0], (i == 13) ? s : 8'h00);
        // startup preload of mask, polarity and enable
        r = nx(nx(r));
        m = r[7:0];
        p = r[15:8];
        @(posedge core_clk);
        preload_valid <= 1'b1;
        preload_mask <= m;
        preload_pol <= p;
        preload_ctl <= 8'h01;
        @(posedge core_clk);
        preload_valid <= 1'b0;
        rdc(8'h0e, m);
        rdc(8'h0f, p);
        rdc(8'h11, 8'h01);
        // clearing write and qualifying edge in one cycle: the edge wins
        f = (p & r[23:16] & ~s) | (~p & ~r[23:16] & s);
        fork
            host.op(1'b1, 1'b0, 8'h10, 8'h00);
            begin
                @(posedge core_clk);
                s <= r[23:16];
            end
        join
        host.op(1'b0, 1'b0, 8'h00, 8'h00);
        rdc(8'h0d, s);
        rdc(8'h10, f);
        chk("irq", |(f & ~m), irq_status);
        summarize;
    end
endmodule

// >>> sim/csif_host.sv
// register bus host model for the flag block
`timescale 1ns/10ps
module csif_host (
    input wire core_clk,
    input wire [7:0] reg_rdata_q,
    output reg reg_wr = 1'b0,
    output reg reg_rd = 1'b0,
    output reg [7:0] reg_addr = 8'h00,
    output reg [7:0] reg_wdata = 8'h00
);
    reg [7:0] q;
    // q lags one call: data of the read issued by the previous call
    task op(input w, input r, input [7:0] a, input [7:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= (w | r) ? a : ~reg_addr;
        reg_wdata <= w ? d : ~reg_wdata;
        #1 q = reg_rdata_q;
    endtask
endmodule

// >>> sim/csif_properties.sv
// port-level checks of the interrupt flag block
`timescale 1ns/10ps
module csif_props (
    input wire core_clk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_q,
    input wire irq_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(a);
        reg_rd && !reg_wr && reg_addr == a;
    endsequence
    property p_rst;
        disable iff (1'b0) !rst_n |=> reg_rdata_q == 8'h00 && !irq_status;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_mask;
        s_wr(8'h0e) ##1 s_rd(8'h0e) |=> reg_rdata_q == $past(reg_wdata, 2);
    endproperty
    a_mask: assert property (p_mask) else $error("mask");
    property p_pol;
        s_wr(8'h0f) ##1 s_rd(8'h0f) |=> reg_rdata_q == $past(reg_wdata, 2);
    endproperty
    a_pol: assert property (p_pol) else $error("pol");
    property p_quiet;
        s_wr(8'h11) ##0 !reg_wdata[0] |=> !irq_status [*3];
    endproperty
    a_quiet: assert property (p_quiet) else $error("quiet");
    property p_allm;
        s_wr(8'h0e) ##0 reg_wdata == 8'hff |=> !irq_status;
    endproperty
    a_allm: assert property (p_allm) else $error("allmask");
    property p_hold;
        !reg_rd |=> $stable(reg_rdata_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_unmap;
        reg_rd && (reg_addr < 8'h0d || reg_addr > 8'h11) |=> reg_rdata_q == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_crsv;
        s_rd(8'h11) |=> reg_rdata_q[7:2] == 6'h00;
    endproperty
    a_crsv: assert property (p_crsv) else $error("ctl");
endmodule
bind csif_top csif_props chk (.*);

// >>> src/csif_edge_flag.v
// one sticky edge flag with polarity select and write-zero clear
`timescale 1ns/10ps
`include "csif_map.vh"
module csif_edge_flag (
    input wire core_clk,
    input wire rst_n,
    input wire src_level,
    input wire edge_sel,
    input wire flag_enable,
    input wire clear_req,
    output reg flag_q,
    output reg level_q
);
    wire rise;
    wire fall;
    wire hit;
    reg flag_d;
    assign rise = src_level & ~level_q;
    assign fall = ~src_level & level_q;
    assign hit = flag_enable & (edge_sel ? rise : fall);
    always @* begin
        flag_d = flag_q;
        if (clear_req) begin
            flag_d = `CSIF_ZERO_BIT;
        end
        if (hit) begin
            flag_d = 1'b1;
        end
    end
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flag_q <= `CSIF_RST_BIT;
            level_q <= `CSIF_RST_BIT;
        end else begin
            flag_q <= flag_d;
            level_q <= src_level;
        end
    end
endmodule

// >>> src/csif_map.vh
// register map and constants of the clock synth interrupt flag block
`ifndef CSIF_MAP_VH
`define CSIF_MAP_VH
`define CSIF_ADDR_W 8
`define CSIF_DATA_W 8
`define CSIF_NSRC 8
`define CSIF_OFS_LIVE 8'h0d
`define CSIF_OFS_MASK 8'h0e
`define CSIF_OFS_POL 8'h0f
`define CSIF_OFS_FLAG 8'h10
`define CSIF_OFS_CTL 8'h11
`define CSIF_RST_BYTE 8'h00
`define CSIF_RST_BIT 1'b0
`define CSIF_BIT_LOCK_LOST_A 7
`define CSIF_BIT_SIGNAL_LOST_A 6
`define CSIF_BIT_CALIBRATING_A 5
`define CSIF_BIT_LOCK_LOST_B 4
`define CSIF_BIT_SIGNAL_LOST_B 3
`define CSIF_BIT_CALIBRATING_B 2
`define CSIF_BIT_REF_BACK_A 1
`define CSIF_BIT_REF_BACK_B 0
`define CSIF_CTL_EN 0
`define CSIF_CTL_AND 1
`define CSIF_ZERO_BIT 1'b0
`endif

// >>> src/csif_top.v
// interrupt status, mask, polarity and sticky flags of a dual pll clock synth
// Notes on behaviour
// - live register shows sources regardless of enable
// - live bits: lol a..ref back b, 7..0
// - ref switch sources flag automatic return-to-primary
// - mask bit one blocks source from interrupt
// - mask resets zero, preload allowed at startup
// - polarity one: rising edge sets flag
// - polarity zero: falling edge; polarity resets zero
// - flags latch edges, same bits, reset zero
// - flags set only while master enable set; write-zero clears work regardless
// - writing zero clears flag until next edge
// - and mode needs all unmasked; or any
// - enable zero silences status interrupt output
`timescale 1ns/10ps
`include "csif_map.vh"
module csif_top (
    input wire core_clk,
    input wire rst_n,
    input wire lock_lost_a,
    input wire signal_lost_a,
    input wire calibrating_a,
    input wire lock_lost_b,
    input wire signal_lost_b,
    input wire calibrating_b,
    input wire ref_switch_back_a,
    input wire ref_switch_back_b,
    input wire preload_valid,
    input wire [7:0] preload_mask,
    input wire [7:0] preload_pol,
    input wire [7:0] preload_ctl,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    output wire irq_status
);
    wire [7:0] src_vec;
    wire [7:0] live_vec;
    wire [7:0] flag_vec;
    wire [7:0] clear_vec;
    wire [7:0] active_vec;
    reg [7:0] mask_q;
    reg [7:0] pol_q;
    reg irq_en_q;
    reg and_mode_q;
    reg irq_and;
    reg irq_or;
    reg [7:0] rdata_d;

    function addr_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    // source order fixes the bit layout of the live, mask, polarity and flag registers
    assign src_vec[`CSIF_BIT_LOCK_LOST_A] = lock_lost_a;
    assign src_vec[`CSIF_BIT_SIGNAL_LOST_A] = signal_lost_a;
    assign src_vec[`CSIF_BIT_CALIBRATING_A] = calibrating_a;
    assign src_vec[`CSIF_BIT_LOCK_LOST_B] = lock_lost_b;
    assign src_vec[`CSIF_BIT_SIGNAL_LOST_B] = signal_lost_b;
    assign src_vec[`CSIF_BIT_CALIBRATING_B] = calibrating_b;
    assign src_vec[`CSIF_BIT_REF_BACK_A] = ref_switch_back_a;
    assign src_vec[`CSIF_BIT_REF_BACK_B] = ref_switch_back_b;

    // writing one leaves the flag alone, zero clears
    assign clear_vec = (reg_wr && addr_hit(reg_addr, `CSIF_OFS_FLAG)) ? ~reg_wdata :
        `CSIF_RST_BYTE;

    genvar gi;
    generate
        for (gi = 0; gi < `CSIF_NSRC; gi = gi + 1) begin : g_src
            csif_edge_flag u_flag (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .src_level(src_vec[gi]),
                .edge_sel(pol_q[gi]),
                .flag_enable(irq_en_q),
                .clear_req(clear_vec[gi]),
                .flag_q(flag_vec[gi]),
                .level_q(live_vec[gi])
            );
        end
    endgenerate

    // mask, polarity and control registers: reset first, then preload, then bus writes
    always @(posedge core_clk) begin
        if (!rst_n) begin
            mask_q <= `CSIF_RST_BYTE;
            pol_q <= `CSIF_RST_BYTE;
            irq_en_q <= `CSIF_RST_BIT;
            and_mode_q <= `CSIF_RST_BIT;
        end else if (preload_valid) begin
            mask_q <= preload_mask;
            pol_q <= preload_pol;
            irq_en_q <= preload_ctl[`CSIF_CTL_EN];
            and_mode_q <= preload_ctl[`CSIF_CTL_AND];
        end else if (reg_wr) begin
            if (addr_hit(reg_addr, `CSIF_OFS_MASK)) begin
                mask_q <= reg_wdata;
            end
            if (addr_hit(reg_addr, `CSIF_OFS_POL)) begin
                pol_q <= reg_wdata;
            end
            if (addr_hit(reg_addr, `CSIF_OFS_CTL)) begin
                irq_en_q <= reg_wdata[`CSIF_CTL_EN];
                and_mode_q <= reg_wdata[`CSIF_CTL_AND];
            end
        end
    end

    always @* begin
        rdata_d = `CSIF_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `CSIF_OFS_LIVE: rdata_d = live_vec;
                `CSIF_OFS_MASK: rdata_d = mask_q;
                `CSIF_OFS_POL: rdata_d = pol_q;
                `CSIF_OFS_FLAG: rdata_d = flag_vec;
                `CSIF_OFS_CTL: begin
                    rdata_d[`CSIF_CTL_EN] = irq_en_q;
                    rdata_d[`CSIF_CTL_AND] = and_mode_q;
                end
                default: rdata_d = `CSIF_RST_BYTE;
            endcase
        end else begin
            rdata_d = reg_rdata_q;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q <= `CSIF_RST_BYTE;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // masked bits count as active in and mode so they hold it off only when all bits are masked
    assign active_vec = flag_vec & ~mask_q;
    always @* begin
        irq_and = &(flag_vec | mask_q);
        irq_or = |active_vec;
        // all sources masked gives no interrupt in either mode
        if (&mask_q) begin
            irq_and = 1'b0;
        end
    end
    assign irq_status = irq_en_q & (and_mode_q ? irq_and : irq_or);
endmodule
